// >>> hw/rsca_pkg.sv
// Constants shared by the radio settings command block
package rsca_pkg;
  // Frame bytes
  localparam logic [7:0] FRAME_START = 8'h02;
  localparam logic [7:0] CMD_SET = 8'h09;
  localparam logic [7:0] CMD_GET = 8'h0A;
  localparam logic [7:0] RESP_FLAG = 8'h40;
  localparam logic [7:0] GET_LEN = 8'h02;
  localparam logic [7:0] SET_RESP_LEN = 8'h01;
  localparam logic [7:0] LEN_EXTRA = 8'h02;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_FAIL = 8'h01;
  // Setting positions and byte counts
  localparam logic [7:0] POS_OWN_ADDR = 8'h1D;
  localparam logic [7:0] POS_ACK_WAIT = 8'h20;
  localparam logic [7:0] POS_TX_POWER = 8'h29;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_TWO = 8'h02;
  // Reset values
  localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
  localparam logic [15:0] ACK_WAIT_RESET = 16'h000A;
  localparam logic [7:0] TX_POWER_RESET = 8'h0E;
  // Permitted ranges
  localparam logic [7:0] OWN_ADDR_MAX = 8'hFE;
  localparam logic [15:0] ACK_WAIT_MIN = 16'h0005;
  localparam logic signed [7:0] TX_POWER_MIN = -8'sd11;
  localparam logic signed [7:0] TX_POWER_MAX = 8'sd15;
  // Addressing modes that use the own address
  localparam logic [1:0] ADDR_MODE_1 = 2'h1;
  localparam logic [1:0] ADDR_MODE_2 = 2'h2;
  // Timing
  localparam int CLK_HZ = 200000000;
  localparam int MS_PER_S = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
  // Receive/answer sequencer states
  typedef enum logic [7:0] {
    RSCA_S_START = 8'b00000001,
    RSCA_S_CMD = 8'b00000010,
    RSCA_S_LEN = 8'b00000100,
    RSCA_S_POS = 8'b00001000,
    RSCA_S_CNT = 8'b00010000,
    RSCA_S_VAL = 8'b00100000,
    RSCA_S_CS = 8'b01000000,
    RSCA_S_SEND = 8'b10000000
  } rsca_state_t;
endpackage

// >>> hw/rsca_top.sv
// Radio settings store reached through set and get command frames
`timescale 1ns/1ps
module rsca_top #(
  parameter int CYCLES_PER_MS = rsca_pkg::CYCLES_PER_MS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [1:0] addr_mode,
  input wire logic radio_tx_done,
  input wire logic radio_ack_seen,
  output logic radio_retry,
  output logic [7:0] source_address,
  output logic source_address_valid,
  output logic signed [7:0] transmit_power_out,
  output logic [15:0] ack_wait_out
);
  // Elaboration guard: a zero-length millisecond would never expire
  if (CYCLES_PER_MS < 1)
  begin : g_bad_cpm
    $error("CYCLES_PER_MS must be at least 1");
  end

  rsca_pkg::rsca_state_t state;
  logic [7:0] cmd;
  logic [7:0] len;
  logic [7:0] pos;
  logic [7:0] cnt;
  logic [7:0] val_lo;
  logic [7:0] val_hi;
  logic val_idx;
  logic [7:0] rx_cs;
  logic [7:0] tx_cs;
  logic [7:0] resp [0:6];
  logic [2:0] resp_len;
  logic [2:0] resp_idx;
  logic cs_sent;
  logic [7:0] own_address_low;
  logic [15:0] ack_wait_time;
  logic signed [7:0] transmit_power_level;

  ////////////////////////////////////////////////////////////////////////////
  // Frame checks, all combinational
  logic cs_byte_ok;
  logic width_ok;
  logic value_ok;
  logic set_ok;
  logic frame_done;
  logic [7:0] cur_lo;
  logic [7:0] cur_hi;
  logic signed [7:0] power_req;
  logic signed [7:0] power_level;

  assign cs_byte_ok = (rx_data == rx_cs);
  assign frame_done = (state == rsca_pkg::RSCA_S_CS) && rx_valid && cs_byte_ok;
  assign power_req = val_lo;

  // Whole dB steps, so any request up to the top is itself a level
  always_comb
  begin
    power_level = power_req;
    if (power_req > rsca_pkg::TX_POWER_MAX)
      power_level = rsca_pkg::TX_POWER_MAX;
  end

  // Position decides width, range check and stored value
  always_comb
  begin
    width_ok = 1'b0;
    value_ok = 1'b0;
    cur_lo = 8'h00;
    cur_hi = 8'h00;
    case (pos)
      rsca_pkg::POS_OWN_ADDR:
      begin
        width_ok = (cnt == rsca_pkg::CNT_ONE);
        value_ok = (val_lo <= rsca_pkg::OWN_ADDR_MAX);
        cur_lo = own_address_low;
      end
      rsca_pkg::POS_ACK_WAIT:
      begin
        width_ok = (cnt == rsca_pkg::CNT_TWO);
        value_ok = ({val_hi, val_lo} >= rsca_pkg::ACK_WAIT_MIN);
        cur_lo = ack_wait_time[7:0];
        cur_hi = ack_wait_time[15:8];
      end
      rsca_pkg::POS_TX_POWER:
      begin
        width_ok = (cnt == rsca_pkg::CNT_ONE);
        value_ok = (power_req >= rsca_pkg::TX_POWER_MIN);
        cur_lo = transmit_power_level;
      end
      default:
      begin
        width_ok = 1'b0;
      end
    endcase
  end

  assign set_ok = width_ok && value_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Receive parser and answer sender; incoming bytes are ignored while answering
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= rsca_pkg::RSCA_S_START;
      cmd <= 8'h00;
      len <= 8'h00;
      pos <= 8'h00;
      cnt <= 8'h00;
      val_lo <= 8'h00;
      val_hi <= 8'h00;
      val_idx <= 1'b0;
      rx_cs <= 8'h00;
      tx_cs <= 8'h00;
      resp_len <= 3'h0;
      resp_idx <= 3'h0;
      cs_sent <= 1'b0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      for (int i = 0; i < 7; i++)
        resp[i] <= 8'h00;
    end
    else
    begin
      if (rx_valid && state != rsca_pkg::RSCA_S_SEND)
        rx_cs <= rx_cs ^ rx_data;
      case (state)
        rsca_pkg::RSCA_S_START:
        begin
          rx_cs <= rsca_pkg::FRAME_START;
          val_lo <= 8'h00;
          val_hi <= 8'h00;
          val_idx <= 1'b0;
          if (rx_valid && rx_data == rsca_pkg::FRAME_START)
            state <= rsca_pkg::RSCA_S_CMD;
        end
        rsca_pkg::RSCA_S_CMD:
          if (rx_valid)
          begin
            cmd <= rx_data;
            if (rx_data == rsca_pkg::CMD_SET || rx_data == rsca_pkg::CMD_GET)
              state <= rsca_pkg::RSCA_S_LEN;
            else
              state <= rsca_pkg::RSCA_S_START;
          end
        rsca_pkg::RSCA_S_LEN:
          if (rx_valid)
          begin
            len <= rx_data;
            state <= rsca_pkg::RSCA_S_POS;
          end
        rsca_pkg::RSCA_S_POS:
          if (rx_valid)
          begin
            pos <= rx_data;
            state <= rsca_pkg::RSCA_S_CNT;
          end
        rsca_pkg::RSCA_S_CNT:
          if (rx_valid)
          begin
            cnt <= rx_data;
            // Malformed headers drop the frame: no answer can be framed
            if (cmd == rsca_pkg::CMD_GET)
              state <= (len == rsca_pkg::GET_LEN) ? rsca_pkg::RSCA_S_CS
                                                   : rsca_pkg::RSCA_S_START;
            else if (rx_data == rsca_pkg::CNT_ONE || rx_data == rsca_pkg::CNT_TWO)
              state <= (len == rx_data + rsca_pkg::LEN_EXTRA) ? rsca_pkg::RSCA_S_VAL
                                                               : rsca_pkg::RSCA_S_START;
            else
              state <= rsca_pkg::RSCA_S_START;
          end
        rsca_pkg::RSCA_S_VAL:
          if (rx_valid)
          begin
            if (val_idx)
              val_hi <= rx_data;
            else
              val_lo <= rx_data;
            val_idx <= 1'b1;
            if (val_idx || cnt == rsca_pkg::CNT_ONE)
              state <= rsca_pkg::RSCA_S_CS;
          end
        rsca_pkg::RSCA_S_CS:
          if (rx_valid)
          begin
            // Bad check byte: silently dropped, host times out and resends
            state <= cs_byte_ok ? rsca_pkg::RSCA_S_SEND : rsca_pkg::RSCA_S_START;
            resp[0] <= rsca_pkg::FRAME_START;
            resp[1] <= cmd | rsca_pkg::RESP_FLAG;
            tx_cs <= 8'h00;
            resp_idx <= 3'h0;
            cs_sent <= 1'b0;
            if (cmd == rsca_pkg::CMD_SET)
            begin
              resp[2] <= rsca_pkg::SET_RESP_LEN;
              resp[3] <= set_ok ? rsca_pkg::STATUS_OK : rsca_pkg::STATUS_FAIL;
              resp_len <= 3'h4;
            end
            else if (width_ok)
            begin
              resp[2] <= cnt + rsca_pkg::LEN_EXTRA;
              resp[3] <= pos;
              resp[4] <= cnt;
              resp[5] <= cur_lo;
              resp[6] <= cur_hi;
              resp_len <= (cnt == rsca_pkg::CNT_TWO) ? 3'h7 : 3'h6;
            end
            else
            begin
              // Unknown position or count: answered like a failed set
              resp[2] <= rsca_pkg::SET_RESP_LEN;
              resp[3] <= rsca_pkg::STATUS_FAIL;
              resp_len <= 3'h4;
            end
          end
        rsca_pkg::RSCA_S_SEND:
          if (!tx_valid || tx_ready)
          begin
            if (resp_idx < resp_len)
            begin
              tx_data <= resp[resp_idx];
              tx_cs <= tx_cs ^ resp[resp_idx];
              resp_idx <= resp_idx + 3'h1;
              tx_valid <= 1'b1;
            end
            else if (!cs_sent)
            begin
              tx_data <= tx_cs;
              cs_sent <= 1'b1;
              tx_valid <= 1'b1;
            end
            else
            begin
              tx_valid <= 1'b0;
              state <= rsca_pkg::RSCA_S_START;
            end
          end
        default:
          state <= rsca_pkg::RSCA_S_START;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setting store, written only by a checked set frame; power requests above the top are stored clamped
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      own_address_low <= rsca_pkg::OWN_ADDR_RESET;
      ack_wait_time <= rsca_pkg::ACK_WAIT_RESET;
      transmit_power_level <= rsca_pkg::TX_POWER_RESET;
    end
    else if (frame_done && cmd == rsca_pkg::CMD_SET && set_ok)
    begin
      case (pos)
        rsca_pkg::POS_OWN_ADDR: own_address_low <= val_lo;
        rsca_pkg::POS_ACK_WAIT: ack_wait_time <= {val_hi, val_lo};
        rsca_pkg::POS_TX_POWER: transmit_power_level <= power_level;
        default: own_address_low <= own_address_low;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs toward the radio, registered
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      source_address <= 8'h00;
      source_address_valid <= 1'b0;
      transmit_power_out <= rsca_pkg::TX_POWER_RESET;
      ack_wait_out <= rsca_pkg::ACK_WAIT_RESET;
    end
    else
    begin
      source_address_valid <= (addr_mode == rsca_pkg::ADDR_MODE_1)
                              || (addr_mode == rsca_pkg::ADDR_MODE_2);
      source_address <= ((addr_mode == rsca_pkg::ADDR_MODE_1)
                         || (addr_mode == rsca_pkg::ADDR_MODE_2)) ? own_address_low : 8'h00;
      transmit_power_out <= transmit_power_level;
      ack_wait_out <= ack_wait_time;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ack wait timer; the value is sampled at the start, later writes apply next time
  logic ack_busy;
  logic [15:0] ms_left;
  logic [31:0] sub_ms;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ack_busy <= 1'b0;
      ms_left <= 16'h0000;
      sub_ms <= 32'h00000000;
      radio_retry <= 1'b0;
    end
    else
    begin
      radio_retry <= 1'b0;
      if (radio_tx_done)
      begin
        ack_busy <= 1'b1;
        ms_left <= ack_wait_time;
        sub_ms <= 32'h00000000;
      end
      else if (ack_busy)
      begin
        if (radio_ack_seen)
          ack_busy <= 1'b0;
        else if (sub_ms == 32'(CYCLES_PER_MS - 1))
        begin
          sub_ms <= 32'h00000000;
          if (ms_left == 16'h0001)
          begin
            ack_busy <= 1'b0;
            radio_retry <= 1'b1;
          end
          ms_left <= ms_left - 16'h0001;
        end
        else
          sub_ms <= sub_ms + 32'h00000001;
      end
    end
  end
endmodule

// >>> sim/rsca_checker.sv
// Port-level checker for the radio settings command block
`timescale 1ns/1ps
module rsca_checker #(
  parameter int CYCLES_PER_MS = rsca_pkg::CYCLES_PER_MS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [1:0] addr_mode,
  input wire logic radio_tx_done,
  input wire logic radio_ack_seen,
  input wire logic radio_retry,
  input wire logic [7:0] source_address,
  input wire logic source_address_valid,
  input wire logic signed [7:0] transmit_power_out,
  input wire logic [15:0] ack_wait_out
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Reference cycle count since the last send; wait value taken from the
  // registered copy, so a write just before a send is not modelled
  logic wait_on;
  logic [15:0] wait_ms;
  logic [31:0] wait_cyc;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wait_on <= 1'b0;
      wait_ms <= 16'h0000;
      wait_cyc <= 32'h00000000;
    end
    else if (radio_tx_done)
    begin
      wait_on <= 1'b1;
      wait_ms <= ack_wait_out;
      wait_cyc <= 32'h00000001;
    end
    else if (radio_ack_seen || radio_retry)
      wait_on <= 1'b0;
    else
      wait_cyc <= wait_cyc + 32'h00000001;
  end
  // Retry exactly when the whole wait has run out
  a_retry_time: assert property (radio_retry |->
    wait_on && wait_cyc == 32'(wait_ms) * 32'(CYCLES_PER_MS) + 32'h00000001)
    else $error("retry not at end of ack wait");
  // Own address shown only in modes 1 and 2
  a_src_shown: assert property ((addr_mode == 2'h1 || addr_mode == 2'h2) |=> source_address_valid)
    else $error("source address not flagged in own-address mode");
  a_src_hidden: assert property (!(addr_mode == 2'h1 || addr_mode == 2'h2) |=>
    !source_address_valid && source_address == 8'h00)
    else $error("source address shown in other mode");
  // Answer byte held while the sink stalls
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("answer byte dropped during stall");
  a_ack_floor: assert property (ack_wait_out >= 16'h0005)
    else $error("ack wait below minimum");
  a_power_span: assert property (transmit_power_out >= -8'sd11 && transmit_power_out <= 8'sd15)
    else $error("power level out of span");
  a_retry_pulse: assert property (radio_retry |=> !radio_retry)
    else $error("retry longer than one cycle");
  // Shortest wait is 5 ms, so no retry soon after a send
  a_retry_early: assert property (radio_tx_done |=> !radio_retry [*8])
    else $error("retry too soon after send");
  a_store_quiet: assert property (!rx_valid [*2] |=>
    $stable(ack_wait_out) && $stable(transmit_power_out))
    else $error("setting changed with no frame");
  c_answer: cover property (tx_valid && tx_ready);
  c_retry: cover property (radio_retry);
  c_own_addr: cover property (source_address_valid && source_address == 8'h01);
endmodule
bind rsca_top rsca_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_rsca_checker (
  .ref_clk(ref_clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .addr_mode(addr_mode),
  .radio_tx_done(radio_tx_done), .radio_ack_seen(radio_ack_seen), .radio_retry(radio_retry),
  .source_address(source_address), .source_address_valid(source_address_valid),
  .transmit_power_out(transmit_power_out), .ack_wait_out(ack_wait_out));

// >>> sim/rsca_host.sv
// Host controller model: sends command frames and collects answers
`timescale 1ns/1ps
module rsca_host (
  input wire logic ref_clk,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] got[$];
  logic slow = 1'b0;
  logic [7:0] last = 8'h00;
  initial
  begin
    rx_data = 8'hFF;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  ////////////////////////////////////////
  // Bytes in order, check byte last; idle line shows the inverse of the last byte
  task automatic send(input logic [7:0] b[$], input logic bad);
    logic [7:0] cs;
    cs = 8'h00;
    foreach (b[i])
      cs ^= b[i];
    b.push_back(bad ? ~cs : cs);
    foreach (b[i])
    begin
      @(posedge ref_clk);
      rx_data <= b[i];
      rx_valid <= 1'b1;
      last = b[i];
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_data <= ~last;
  endtask
  // Sink, stalling every other cycle when slow
  always @(posedge ref_clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule

// >>> sim/rsca_top_tb.sv
// Self-checking bench for the radio settings command block
`timescale 1ns/1ps
module rsca_top_tb;
  localparam int CPM = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rx_data, tx_data, source_address;
  logic rx_valid, tx_valid, tx_ready, radio_retry, source_address_valid;
  logic [1:0] addr_mode = 2'h0;
  logic radio_tx_done = 1'b0;
  logic radio_ack_seen = 1'b0;
  logic signed [7:0] transmit_power_out;
  logic [15:0] ack_wait_out;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // Short millisecond keeps the ack timer runs brief
  rsca_top #(.CYCLES_PER_MS(CPM)) u_rsca_top (.ref_clk(ref_clk), .rst(rst), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .addr_mode(addr_mode), .radio_tx_done(radio_tx_done), .radio_ack_seen(radio_ack_seen),
    .radio_retry(radio_retry), .source_address(source_address),
    .source_address_valid(source_address_valid), .transmit_power_out(transmit_power_out),
    .ack_wait_out(ack_wait_out));
  rsca_host u_rsca_host (.ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  ////////////////////////////////////////
  // Clock and hang guard
  initial
    forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One frame out, whole answer back, byte by byte
  task automatic xact(input logic [7:0] req[$], input logic [7:0] rsp[$]);
    logic [7:0] cs;
    int n;
    cs = 8'h00;
    n = 0;
    u_rsca_host.got.delete();
    u_rsca_host.send(req, 1'b0);
    foreach (rsp[i])
      cs ^= rsp[i];
    rsp.push_back(cs);
    while (u_rsca_host.got.size() < rsp.size() && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (4) @(posedge ref_clk);
    chk("answer length", 16'(u_rsca_host.got.size()), 16'(rsp.size()));
    foreach (rsp[i])
      chk("answer byte", 16'(u_rsca_host.got[i]), 16'(rsp[i]));
  endtask
  task automatic set(input logic [7:0] pos, input logic [7:0] cnt, input logic [15:0] v,
    input logic [7:0] st);
    if (cnt == 8'h01)
      xact('{8'h02, 8'h09, 8'h03, pos, 8'h01, v[7:0]}, '{8'h02, 8'h49, 8'h01, st});
    else
      xact('{8'h02, 8'h09, 8'h04, pos, 8'h02, v[7:0], v[15:8]}, '{8'h02, 8'h49, 8'h01, st});
  endtask
  task automatic get(input logic [7:0] pos, input logic [7:0] cnt, input logic [15:0] v);
    if (cnt == 8'h01)
      xact('{8'h02, 8'h0A, 8'h02, pos, 8'h01}, '{8'h02, 8'h4A, 8'h03, pos, 8'h01, v[7:0]});
    else
      xact('{8'h02, 8'h0A, 8'h02, pos, 8'h02},
        '{8'h02, 8'h4A, 8'h04, pos, 8'h02, v[7:0], v[15:8]});
  endtask
  ////////////////////////////////////////
  task automatic t_defaults();
    get(8'h1D, 8'h01, 16'h0000);
    get(8'h20, 8'h02, 16'h000A);
    get(8'h29, 8'h01, 16'h000E);
    chk("ack wait out", ack_wait_out, 16'h000A);
    chk("power out", 16'(transmit_power_out), 16'h000E);
  endtask
  task automatic t_addr();
    set(8'h1D, 8'h01, 16'h0001, 8'h00);
    set(8'h1D, 8'h01, 16'h00FF, 8'h01);
    get(8'h1D, 8'h01, 16'h0001);
    for (int m = 0; m < 4; m++)
    begin
      @(posedge ref_clk);
      addr_mode <= 2'(m);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("source valid", 16'(source_address_valid), 16'(m == 1 || m == 2));
      chk("source addr", 16'(source_address), 16'(m == 1 || m == 2));
    end
  endtask
  task automatic t_ack();
    int n;
    set(8'h20, 8'h02, 16'h000F, 8'h00);
    set(8'h20, 8'h02, 16'h0004, 8'h01);
    get(8'h20, 8'h02, 16'h000F);
    set(8'h20, 8'h02, 16'h0005, 8'h00);
    chk("ack wait out", ack_wait_out, 16'h0005);
    radio_tx_done <= 1'b1;
    @(posedge ref_clk);
    radio_tx_done <= 1'b0;
    n = 0;
    while (radio_retry !== 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("retry delay ok", 16'(n >= 5 * CPM - 2 && n <= 5 * CPM + 2), 16'h0001);
    @(posedge ref_clk);
    radio_tx_done <= 1'b1;
    @(posedge ref_clk);
    radio_tx_done <= 1'b0;
    repeat (5) @(posedge ref_clk);
    radio_ack_seen <= 1'b1;
    @(posedge ref_clk);
    radio_ack_seen <= 1'b0;
    n = 0;
    repeat (40)
    begin
      @(posedge ref_clk);
      #1;
      n += (radio_retry === 1'b1);
    end
    chk("retry after ack", 16'(n), 16'h0000);
  endtask
  task automatic t_power();
    set(8'h29, 8'h01, 16'h0014, 8'h00);
    get(8'h29, 8'h01, 16'h000F);
    set(8'h29, 8'h01, 16'h00F5, 8'h00);
    get(8'h29, 8'h01, 16'h00F5);
    chk("power out", 16'(transmit_power_out), 16'hFFF5);
    set(8'h29, 8'h01, 16'h00F4, 8'h01);
    get(8'h29, 8'h01, 16'h00F5);
  endtask
  // Corrupt check byte must be ignored; then a read under a stalling sink
  task automatic t_bad();
    u_rsca_host.slow = 1'b1;
    u_rsca_host.got.delete();
    u_rsca_host.send('{8'h02, 8'h0A, 8'h02, 8'h29, 8'h01}, 1'b1);
    repeat (30) @(posedge ref_clk);
    chk("dropped frame", 16'(u_rsca_host.got.size()), 16'h0000);
    get(8'h20, 8'h02, 16'h0005);
    // Set with a length that disagrees with its count: dropped, store untouched
    u_rsca_host.got.delete();
    u_rsca_host.send('{8'h02, 8'h09, 8'h05, 8'h1D, 8'h01, 8'h07}, 1'b0);
    repeat (30) @(posedge ref_clk);
    chk("dropped set", 16'(u_rsca_host.got.size()), 16'h0000);
    get(8'h1D, 8'h01, 16'h0001);
    // Unknown position and wrong count give the failure answer
    set(8'h2A, 8'h01, 16'h0064, 8'h01);
    xact('{8'h02, 8'h0A, 8'h02, 8'h1D, 8'h02}, '{8'h02, 8'h4A, 8'h01, 8'h01});
    // Distinct high and low bytes prove the byte order both ways
    set(8'h20, 8'h02, 16'h0102, 8'h00);
    get(8'h20, 8'h02, 16'h0102);
    u_rsca_host.slow = 1'b0;
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_defaults();
    t_addr();
    t_ack();
    t_power();
    t_bad();
    // Mid-run reset must bring every default back
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_defaults();
    print_verdict();
  end
endmodule
